/* File: hdl/ppc_pkg.sv */
// Package with register map, field layout and timing constants of the PWM control slice
// Notes on behaviour
// - Clock B divides bus clock by power-of-two code
// - Clock A divides bus clock likewise, own field
// - Prescaler select writable anytime, glitch allowed
// - Alignment bit one selects centre aligned channel
// - Three pairing bits join adjacent channels sixteen-bit
// - Even channel high byte, odd channel low
// - Paired output on odd pin, odd controls
// - Wait-stop bit gates prescaler during wait mode
// - Freeze-stop bit gates prescaler during freeze mode
// - Registers accessible in freeze; clock resumes
// - Paired even channel enable ignored, output off
package ppc_pkg;
  // Register byte addresses
  localparam logic [11:0] ADDR_PRESCALE = 12'h000;
  localparam logic [11:0] ADDR_ALIGN = 12'h004;
  localparam logic [11:0] ADDR_CONTROL = 12'h008;
  localparam logic [11:0] ADDR_ENABLE = 12'h00c;
  localparam logic [11:0] ADDR_STATUS = 12'h010;
  // Field positions
  localparam int CLK_A_SEL_LSB = 0;
  localparam int CLK_B_SEL_LSB = 4;
  localparam int SEL_W = 3;
  localparam int FREEZE_BIT = 2;
  localparam int WAIT_BIT = 3;
  localparam int PAIR01_BIT = 4;
  localparam int PAIR23_BIT = 5;
  localparam int PAIR45_BIT = 6;
  localparam int NCHAN = 6;
  // Writable masks and reset values
  localparam logic [7:0] PRESCALE_MASK = 8'h77;
  localparam logic [7:0] ALIGN_MASK = 8'h3f;
  localparam logic [7:0] CONTROL_MASK = 8'h7c;
  localparam logic [7:0] ENABLE_MASK = 8'h3f;
  localparam logic [7:0] REG_RESET = 8'h00;
  // Prescaler counter width, longest divide is 128
  localparam int PRE_W = 7;
  // Control register values
  typedef struct packed {
    logic [7:0] prescale;
    logic [7:0] align;
    logic [7:0] control;
    logic [7:0] enable;
  } ppc_regs_s;
  // Per-channel effective controls handed to the channel logic
  typedef struct packed {
    logic [5:0] eff_enable;
    logic [5:0] eff_center;
    logic [2:0] pair;
  } ppc_chan_s;
endpackage

/* File: hdl/ppc_prescaler.sv */
// Power-of-two prescaler producing clock A and clock B enables
`timescale 1ns/1ps
module ppc_prescaler (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic run,
  input wire logic [2:0] sel_a,
  input wire logic [2:0] sel_b,
  // Tick outputs
  output logic tick_a,
  output logic tick_b
);
  typedef struct packed {
    logic [ppc_pkg::PRE_W-1:0] cnt;
    logic ta;
    logic tb;
  } ppc_pre_s;
  ppc_pre_s st_ff;
  ppc_pre_s nxt_st;

  // Tick when low sel bits of the free counter are all ones
  function automatic logic hit(input logic [ppc_pkg::PRE_W-1:0] c, input logic [2:0] s);
    logic [ppc_pkg::PRE_W-1:0] m;
    m = (ppc_pkg::PRE_W)'((8'h01 << s) - 8'h01);
    hit = ((c & m) == m);
  endfunction

  // Next state; counter holds when run is low
  always_comb begin
    nxt_st = st_ff;
    nxt_st.ta = 1'b0;
    nxt_st.tb = 1'b0;
    if (run) begin
      nxt_st.cnt = st_ff.cnt + 1'b1;
      nxt_st.ta = hit(st_ff.cnt, sel_a);
      nxt_st.tb = hit(st_ff.cnt, sel_b);
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign tick_a = st_ff.ta;
  assign tick_b = st_ff.tb;

  // Undivided setting ticks every running cycle
  undiv_a: assert property (@(posedge pclk) disable iff (!presetn)
    (run && sel_a == 3'h0) |=> tick_a) else $error("clock A not undivided");
  // Stopped prescaler yields no tick
  stop_tick_a: assert property (@(posedge pclk) disable iff (!presetn)
    !run |=> !tick_a && !tick_b) else $error("tick while stopped");
endmodule

/* File: hdl/ppc_top.sv */
// APB control slice: prescalers, alignment, pairing, wait and freeze gating
//
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module ppc_top (
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Processor modes
  input wire logic wait_mode,
  input wire logic freeze_mode,
  // Derived controls
  output logic clk_a_tick,
  output logic clk_b_tick,
  output logic prescale_run,
  output logic [5:0] chan_enable_eff,
  output logic [5:0] chan_center_align_eff,
  output logic [2:0] pair_mask,
  output logic [5:0] pwm_output_port_en
);
  typedef struct packed {
    ppc_pkg::ppc_regs_s regs;
    logic [31:0] rdata;
    logic rdy;
    logic err;
    logic run;
    ppc_pkg::ppc_chan_s ch;
    logic [5:0] pin_en;
  } ppc_top_s;
  ppc_top_s st_ff;
  ppc_top_s nxt_st;
  logic tick_a;
  logic tick_b;

  // Pairing mask per channel: even channel of a joined pair drops out
  function automatic logic [5:0] even_off(input logic [2:0] p);
    even_off = {1'b0, p[2], 1'b0, p[1], 1'b0, p[0]};
  endfunction

  // Odd channel copies its own control bit; even keeps its own when unpaired
  function automatic logic [5:0] eff_bits(input logic [5:0] b, input logic [2:0] p);
    eff_bits = b & ~even_off(p);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    logic acc;
    logic [7:0] wb;
    logic [2:0] pr;
    acc = psel && penable;
    wb = pwdata[7:0];
    nxt_st = st_ff;
    nxt_st.rdy = 1'b0;
    nxt_st.err = 1'b0;
    // Zero wait: ready in the access cycle after setup
    if (psel && !penable) begin
      nxt_st.rdy = 1'b1;
      unique case (paddr)
        ppc_pkg::ADDR_PRESCALE, ppc_pkg::ADDR_ALIGN, ppc_pkg::ADDR_CONTROL,
        ppc_pkg::ADDR_ENABLE, ppc_pkg::ADDR_STATUS: nxt_st.err = 1'b0;
        default: nxt_st.err = 1'b1; // Unmapped address
      endcase
    end
    // Writes land at the completing edge; reachable in any mode
    if (acc && st_ff.rdy && pwrite) begin
      unique case (paddr)
        ppc_pkg::ADDR_PRESCALE: nxt_st.regs.prescale = wb & ppc_pkg::PRESCALE_MASK;
        ppc_pkg::ADDR_ALIGN: nxt_st.regs.align = wb & ppc_pkg::ALIGN_MASK;
        ppc_pkg::ADDR_CONTROL: nxt_st.regs.control = wb & ppc_pkg::CONTROL_MASK;
        ppc_pkg::ADDR_ENABLE: nxt_st.regs.enable = wb & ppc_pkg::ENABLE_MASK;
        default: nxt_st.regs = st_ff.regs; // Status and unmapped ignore writes
      endcase
    end
    // Read data prepared in setup cycle
    nxt_st.rdata = 32'h0000_0000;
    if (psel && !penable && !pwrite) begin
      unique case (paddr)
        ppc_pkg::ADDR_PRESCALE: nxt_st.rdata = {24'h000000, st_ff.regs.prescale};
        ppc_pkg::ADDR_ALIGN: nxt_st.rdata = {24'h000000, st_ff.regs.align};
        ppc_pkg::ADDR_CONTROL: nxt_st.rdata = {24'h000000, st_ff.regs.control};
        ppc_pkg::ADDR_ENABLE: nxt_st.rdata = {24'h000000, st_ff.regs.enable};
        ppc_pkg::ADDR_STATUS: nxt_st.rdata = {16'h0000, st_ff.pin_en, st_ff.ch.eff_center,
                                              st_ff.ch.pair, st_ff.run};
        default: nxt_st.rdata = 32'h0000_0000;
      endcase
    end else if (acc) begin
      nxt_st.rdata = st_ff.rdata;
    end
    // Prescaler input gate
    nxt_st.run = !(wait_mode && st_ff.regs.control[ppc_pkg::WAIT_BIT])
      && !(freeze_mode && st_ff.regs.control[ppc_pkg::FREEZE_BIT]);
    // Pairing and per-channel effective controls
    pr = {st_ff.regs.control[ppc_pkg::PAIR45_BIT], st_ff.regs.control[ppc_pkg::PAIR23_BIT],
          st_ff.regs.control[ppc_pkg::PAIR01_BIT]};
    nxt_st.ch.pair = pr;
    nxt_st.ch.eff_enable = eff_bits(st_ff.regs.enable[5:0], pr);
    nxt_st.ch.eff_center = eff_bits(st_ff.regs.align[5:0], pr);
    nxt_st.pin_en = eff_bits(st_ff.regs.enable[5:0], pr);
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Prescaler instance
  ppc_prescaler u_pre (
    .pclk(pclk),
    .presetn(presetn),
    .run(st_ff.run),
    .sel_a(st_ff.regs.prescale[ppc_pkg::CLK_A_SEL_LSB +: ppc_pkg::SEL_W]),
    .sel_b(st_ff.regs.prescale[ppc_pkg::CLK_B_SEL_LSB +: ppc_pkg::SEL_W]),
    .tick_a(tick_a),
    .tick_b(tick_b)
  );

  // Outputs from flops
  assign prdata = st_ff.rdata;
  assign pready = st_ff.rdy;
  assign pslverr = st_ff.err;
  assign clk_a_tick = tick_a;
  assign clk_b_tick = tick_b;
  assign prescale_run = st_ff.run;
  assign chan_enable_eff = st_ff.ch.eff_enable;
  assign chan_center_align_eff = st_ff.ch.eff_center;
  assign pair_mask = st_ff.ch.pair;
  assign pwm_output_port_en = st_ff.pin_en;

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  wait_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wait_mode && st_ff.regs.control[3]) |=> !prescale_run) else $error("wait gate");
  freeze_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    (freeze_mode && st_ff.regs.control[2]) |=> !prescale_run) else $error("freeze gate");
  resume_run_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!wait_mode && !freeze_mode) |=> prescale_run) else $error("no resume");
  pair_even_a: assert property (@(posedge pclk) disable iff (!presetn)
    pair_mask[0] |-> !chan_enable_eff[0] && !pwm_output_port_en[0])
    else $error("even pin on");
  odd_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 chan_center_align_eff[1] == $past(st_ff.regs.align[1])) else $error("odd align");
  align_pass_a: assert property (@(posedge pclk) disable iff (!presetn)
    !pair_mask[2] |-> chan_center_align_eff[4] == $past(st_ff.regs.align[4]))
    else $error("align");
  pair_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 pair_mask[1] == $past(st_ff.regs.control[5])) else $error("pair bit");
  // Only a completing bus write may move a register while the prescaler is stopped
  hold_run_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!prescale_run && !(psel && penable && pready && pwrite)) |=> $stable(st_ff.regs))
    else $error("regs moved");
endmodule

/* File: test/tb.sv */
// Self-checking bench for the PWM prescale, alignment and pairing control slice
`timescale 1ns/1ps
module tb;
  ////////////////////////////////////////////////////////////////////////////
  // Stimulus and observed signals
  logic pclk, presetn, psel, penable, pwrite, wait_mode, freeze_mode;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, clk_a_tick, clk_b_tick, prescale_run, er;
  logic [5:0] chan_enable_eff, chan_center_align_eff, pwm_output_port_en;
  logic [2:0] pair_mask;
  int err_count = 0, n_tests = 0, cyc = 0, n;
  ppc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .wait_mode(wait_mode), .freeze_mode(freeze_mode),
    .clk_a_tick(clk_a_tick), .clk_b_tick(clk_b_tick), .prescale_run(prescale_run),
    .chan_enable_eff(chan_enable_eff), .chan_center_align_eff(chan_center_align_eff),
    .pair_mask(pair_mask), .pwm_output_port_en(pwm_output_port_en));
  ////////////////////////////////////////////////////////////////////////////
  // Clock at 50 MHz and a hang guard well above the expected run length
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      close_out();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Shared helpers
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One APB transfer; request held until pready is sampled high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Let derived outputs follow a register or mode change
  task settle();
    repeat (3) @(posedge pclk);
  endtask
  // Cycles between two ticks, skipping the first gap after a select change
  task gap(input bit b);
    n = 0;
    repeat (2) do @(posedge pclk); while ((b ? clk_b_tick : clk_a_tick) !== 1'b1);
    do begin
      @(posedge pclk);
      n++;
    end while ((b ? clk_b_tick : clk_a_tick) !== 1'b1);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task t_reset_and_masks();
    apb(1'b0, ppc_pkg::ADDR_CONTROL, 32'h0);
    chk("control reset", rd, 32'h0);
    apb(1'b1, ppc_pkg::ADDR_ALIGN, 32'hffff_ffff);
    apb(1'b0, ppc_pkg::ADDR_ALIGN, 32'h0);
    chk("align mask", rd, 32'h3f);
    apb(1'b0, 12'h014, 32'h0);
    chk("unmapped error", {31'h0, er}, 32'h1);
  endtask
  // Every select code on both prescalers, codes crossed to catch swapped fields
  task t_divide();
    for (int s = 0; s < 8; s++) begin
      apb(1'b1, ppc_pkg::ADDR_PRESCALE, {25'h0, 3'(7 - s), 1'b0, 3'(s)});
      gap(1'b0);
      chk("clock a period", n, 32'h1 << s);
      gap(1'b1);
      chk("clock b period", n, 32'h1 << (7 - s));
    end
  endtask
  // All pairs joined: even channels lose enable, alignment and pin
  task t_pairing();
    apb(1'b1, ppc_pkg::ADDR_CONTROL, 32'h70);
    apb(1'b1, ppc_pkg::ADDR_ENABLE, 32'h3f);
    settle();
    chk("pair mask", pair_mask, 32'h7);
    chk("eff enable", chan_enable_eff, 32'h2a);
    chk("eff align", chan_center_align_eff, 32'h2a);
    chk("pin enable", pwm_output_port_en, 32'h2a);
    apb(1'b1, ppc_pkg::ADDR_STATUS, 32'hffff);
    apb(1'b0, ppc_pkg::ADDR_STATUS, 32'h0);
    chk("status", rd, {16'h0, 6'h2a, 6'h2a, 3'h7, 1'b1});
    apb(1'b1, ppc_pkg::ADDR_ENABLE, 32'h0);
    apb(1'b1, ppc_pkg::ADDR_CONTROL, 32'h10);
    apb(1'b1, ppc_pkg::ADDR_ENABLE, 32'h3f);
    settle();
    chk("one pair", chan_enable_eff, 32'h3e);
    // Channels off before the stop scenario rewrites the control register
    apb(1'b1, ppc_pkg::ADDR_ENABLE, 32'h0);
  endtask
  // Wait and freeze gating, with register access while frozen
  task t_stop();
    wait_mode <= 1'b1;
    settle();
    chk("wait, bit clear", prescale_run, 32'h1);
    apb(1'b1, ppc_pkg::ADDR_CONTROL, 32'h08);
    settle();
    chk("wait, bit set", prescale_run, 32'h0);
    n = 0;
    repeat (16) begin
      @(posedge pclk);
      n += (clk_a_tick !== 1'b0);
    end
    chk("no ticks stopped", n, 32'h0);
    wait_mode <= 1'b0;
    freeze_mode <= 1'b1;
    apb(1'b1, ppc_pkg::ADDR_CONTROL, 32'h04);
    settle();
    chk("freeze, bit set", prescale_run, 32'h0);
    apb(1'b0, ppc_pkg::ADDR_CONTROL, 32'h0);
    chk("read in freeze", rd, 32'h04);
    apb(1'b1, ppc_pkg::ADDR_CONTROL, 32'h0);
    settle();
    chk("resume by clear", prescale_run, 32'h1);
    freeze_mode <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task close_out();
    $display("Mismatches %0d of %0d comparisons", err_count, n_tests);
    if (err_count == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    {presetn, psel, penable, pwrite, wait_mode, freeze_mode} = 6'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_and_masks();
    t_divide();
    t_pairing();
    t_stop();
    close_out();
  end
endmodule
